// File: hw/tbf_card.sv
// Card end of the block frame handler
`timescale 1ns/1ps
module tbf_card
    import tbf_pkg::*;
#(
    parameter int DEPTH = TBF_APDU_DEPTH
)
(
    input wire logic clk,
    input wire logic srst,
    tbf_link_if.card link,
    output logic [7:0] cmd_data,
    output logic cmd_valid,
    output logic cmd_end,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_end,
    output logic rsp_ready,
    output logic [7:0] ifsd,
    output logic [7:0] edc_choice,
    output logic frame_err
);
    typedef enum logic [2:0] {TBF_RX_NAD, TBF_RX_PCB, TBF_RX_LEN, TBF_RX_INF,
                              TBF_RX_EDC, TBF_RX_DROP} tbf_rxst_t;
    typedef enum logic [1:0] {TBF_C_IDLE, TBF_C_FILL, TBF_C_SEND, TBF_C_WAIT} tbf_cst_t;
    tbf_rxst_t rx_r;
    tbf_cst_t cs_r;
    logic [7:0] nad_r, pcb_r, len_r, cnt_r, lrc_r, inf0_r;
    logic [7:0] rsp_buf [0:DEPTH-1];
    logic [8:0] rsp_cnt_r, rsp_pos_r;
    logic nr_r, ns_r;
    logic [7:0] blk_len_r;
    logic tx_start_r;
    logic [7:0] tx_pcb_r, tx_len_r;
    logic pay_rd, tx_busy;
    logic [7:0] rd_ptr_r;

    assign edc_choice = TBF_EDC_CHOICE;
    wire logic byte_in = link.t2c_valid;
    wire logic [7:0] b = link.t2c_data;
    wire logic lrc_ok = (lrc_r == b);
    wire logic nad_ok = (nad_r == TBF_NAD_DEFAULT);
    wire tbf_blk_t blk = tbf_type(pcb_r);
    wire logic len_ok = (blk == TBF_BLK_I) ? (len_r != 8'h00 && len_r <= TBF_MAX_INF) :
                        (blk == TBF_BLK_R) ? (len_r == 8'h00) :
                        (len_r == tbf_s_len(pcb_r));
    wire logic frame_done = byte_in && rx_r == TBF_RX_EDC;
    wire logic good = frame_done && lrc_ok && len_ok;
    wire logic ifs_bad = (inf0_r == 8'h00) || (inf0_r > TBF_MAX_INF);
    wire logic [8:0] remain = rsp_cnt_r - rsp_pos_r;
    wire logic [8:0] chunk = (remain > {1'b0, ifsd}) ? {1'b0, ifsd} : remain;
    wire logic more = (remain > {1'b0, ifsd});
    assign rsp_ready = (cs_r == TBF_C_FILL);

    tbf_tx tbf_tx_inst (
        .clk(clk),
        .srst(srst),
        .start(tx_start_r),
        .pcb(tx_pcb_r),
        .len(tx_len_r),
        .pay_data(tx_pcb_r[7] ? inf0_r : rsp_buf[rsp_pos_r[7:0] + rd_ptr_r]),
        .pay_rd(pay_rd),
        .busy(tx_busy),
        .out_data(link.c2t_data),
        .out_valid(link.c2t_valid),
        .out_last(link.c2t_last)
    );

    always_ff @(posedge clk) begin
        if (rsp_ready && rsp_valid) begin
            rsp_buf[rsp_cnt_r[7:0]] <= rsp_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_r <= TBF_RX_NAD;
            cs_r <= TBF_C_IDLE;
            nad_r <= 8'h00;
            pcb_r <= 8'h00;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            lrc_r <= 8'h00;
            inf0_r <= 8'h00;
            rsp_cnt_r <= 9'h000;
            rsp_pos_r <= 9'h000;
            nr_r <= 1'b0;
            ns_r <= 1'b0;
            blk_len_r <= 8'h00;
            tx_start_r <= 1'b0;
            tx_pcb_r <= 8'h00;
            tx_len_r <= 8'h00;
            rd_ptr_r <= 8'h00;
            ifsd <= TBF_IFSD_RESET;
            cmd_valid <= 1'b0;
            cmd_end <= 1'b0;
            cmd_data <= 8'h00;
            frame_err <= 1'b0;
        end else begin
            tx_start_r <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_end <= 1'b0;
            frame_err <= frame_done && !(lrc_ok && len_ok && nad_ok);
            rd_ptr_r <= pay_rd ? rd_ptr_r + 8'h01 : 8'h00;
            if (byte_in) begin
                lrc_r <= (rx_r == TBF_RX_NAD) ? b : (lrc_r ^ b);
            end
            case (rx_r)
                TBF_RX_NAD: if (byte_in) begin
                    nad_r <= b;
                    rx_r <= TBF_RX_PCB;
                end
                TBF_RX_PCB: if (byte_in) begin
                    pcb_r <= b;
                    rx_r <= TBF_RX_LEN;
                end
                TBF_RX_LEN: if (byte_in) begin
                    len_r <= b;
                    cnt_r <= 8'h00;
                    rx_r <= (b == 8'h00) ? TBF_RX_EDC : (b > TBF_MAX_INF) ? TBF_RX_DROP : TBF_RX_INF;
                end
                TBF_RX_INF: if (byte_in) begin
                    if (cnt_r == 8'h00) begin
                        inf0_r <= b;
                    end
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r + 8'h01 == len_r) begin
                        rx_r <= TBF_RX_EDC;
                    end
                end
                TBF_RX_EDC: if (byte_in) begin
                    rx_r <= TBF_RX_NAD;
                end
                TBF_RX_DROP: if (byte_in && link.t2c_last) begin
                    rx_r <= TBF_RX_NAD;
                end
                default: rx_r <= TBF_RX_NAD;
            endcase
            if (frame_done && !tx_busy) begin
                tx_start_r <= 1'b1;
                tx_len_r <= 8'h00;
                tx_pcb_r <= TBF_PCB_R | (nr_r ? TBF_PCB_NR_BIT : 8'h00);
                if (!(lrc_ok && len_ok)) begin
                    tx_pcb_r <= TBF_PCB_R | (nr_r ? TBF_PCB_NR_BIT : 8'h00) | TBF_R_ERR_EDC;
                end else if (!nad_ok) begin
                    tx_pcb_r <= TBF_PCB_R | (nr_r ? TBF_PCB_NR_BIT : 8'h00);
                end else if (blk == TBF_BLK_S && !pcb_r[5]) begin
                    tx_pcb_r <= pcb_r | TBF_S_RESP_BIT;
                    tx_len_r <= tbf_s_len(pcb_r);
                    if (pcb_r[4:0] == TBF_S_IFS[4:0]) begin
                        if (ifs_bad) begin
                            tx_pcb_r <= TBF_PCB_R | (nr_r ? TBF_PCB_NR_BIT : 8'h00) | TBF_R_ERR_OTHER;
                            tx_len_r <= 8'h00;
                        end else begin
                            ifsd <= inf0_r;
                        end
                    end else if (pcb_r[4:0] == TBF_S_RESYNCH[4:0]) begin
                        nr_r <= 1'b0;
                        ns_r <= 1'b0;
                        cs_r <= TBF_C_IDLE;
                    end else if (pcb_r[4:0] == TBF_S_ABORT[4:0]) begin
                        rsp_cnt_r <= 9'h000;
                        rsp_pos_r <= 9'h000;
                        cs_r <= TBF_C_IDLE;
                    end
                end else if (blk == TBF_BLK_I) begin
                    tx_start_r <= pcb_r[5];
                    nr_r <= ~pcb_r[6];
                    if (!pcb_r[5]) begin
                        cs_r <= TBF_C_FILL;
                        rsp_cnt_r <= 9'h000;
                        rsp_pos_r <= 9'h000;
                    end
                    tx_pcb_r <= TBF_PCB_R | (pcb_r[6] ? 8'h00 : TBF_PCB_NR_BIT);
                end else if (blk == TBF_BLK_R && cs_r == TBF_C_WAIT) begin
                    tx_start_r <= 1'b0;
                    if (pcb_r[4] != ns_r) begin
                        ns_r <= ~ns_r;
                        rsp_pos_r <= rsp_pos_r + {1'b0, blk_len_r};
                    end
                    cs_r <= TBF_C_SEND;
                end else begin
                    tx_start_r <= 1'b0;
                end
            end
            if (good && nad_ok && blk == TBF_BLK_I && cs_r == TBF_C_IDLE) begin
                cmd_end <= !pcb_r[5];
            end
            if (byte_in && rx_r == TBF_RX_INF && nad_ok) begin
                cmd_data <= b;
                cmd_valid <= 1'b1;
            end
            case (cs_r)
                TBF_C_IDLE: ;
                TBF_C_FILL: if (rsp_valid) begin
                    rsp_cnt_r <= rsp_cnt_r + 9'h001;
                    if (rsp_end) begin
                        cs_r <= TBF_C_SEND;
                    end
                end
                TBF_C_SEND: if (!tx_busy && !tx_start_r) begin
                    tx_start_r <= 1'b1;
                    blk_len_r <= chunk[7:0];
                    tx_len_r <= chunk[7:0];
                    tx_pcb_r <= (ns_r ? TBF_PCB_NS_BIT : 8'h00) |
                                (more ? TBF_PCB_MORE_BIT : 8'h00);
                    if (more) begin
                        cs_r <= TBF_C_WAIT;
                    end else begin
                        ns_r <= ~ns_r;
                        cs_r <= TBF_C_IDLE;
                    end
                end
                TBF_C_WAIT: ;
                default: cs_r <= TBF_C_IDLE;
            endcase
        end
    end
endmodule

// File: hw/tbf_link_if.sv
// Byte link between card and terminal framers
`timescale 1ns/1ps
interface tbf_link_if;
    logic [7:0] t2c_data;
    logic t2c_valid;
    logic t2c_last;
    logic [7:0] c2t_data;
    logic c2t_valid;
    logic c2t_last;
    modport card (input t2c_data, input t2c_valid, input t2c_last,
                  output c2t_data, output c2t_valid, output c2t_last);
    modport term (output t2c_data, output t2c_valid, output t2c_last,
                  input c2t_data, input c2t_valid, input c2t_last);
endinterface

// File: hw/tbf_pkg.sv
// Package of constants and types for the block frame handler
// Notes on behaviour
// - Only node address zero is supported
// - Card sends node address byte zero
// - Nonzero address I-block ignored, R-block answered
// - Control byte alone selects block type
// - I, R and S blocks are supported
// - Length byte equals information field size
// - Information field is 0 to 254 bytes
// - I-block always carries information bytes
// - R-block length is always zero
// - IFS and WTX S-blocks carry one byte
// - Vpp, abort, resync S-blocks carry nothing
// - Bad check byte gives R-block code 1
// - IFS request of 1 to 254 answered with same value, others get R-block code 2
// - Resync request answered with empty response
// - Abort during chaining answered with response
// - Every sent block ends with check byte
// - Rejection carries next expected sequence number
// - Terminal field size 32 at reset, max 254
// - Error detection choice is LRC, value zero
package tbf_pkg;
    localparam logic [7:0] TBF_NAD_DEFAULT = 8'h00;
    localparam logic [7:0] TBF_MAX_INF = 8'hfe;
    localparam logic [7:0] TBF_IFSD_RESET = 8'h20;
    localparam logic [7:0] TBF_EDC_CHOICE = 8'h00;
    localparam logic [7:0] TBF_PCB_R = 8'h80;
    localparam logic [7:0] TBF_PCB_S = 8'hc0;
    localparam logic [7:0] TBF_PCB_NS_BIT = 8'h40;
    localparam logic [7:0] TBF_PCB_NR_BIT = 8'h10;
    localparam logic [7:0] TBF_PCB_MORE_BIT = 8'h20;
    localparam logic [7:0] TBF_R_ERR_EDC = 8'h01;
    localparam logic [7:0] TBF_R_ERR_OTHER = 8'h02;
    localparam logic [7:0] TBF_S_RESP_BIT = 8'h20;
    localparam logic [5:0] TBF_S_RESYNCH = 6'h00;
    localparam logic [5:0] TBF_S_IFS = 6'h01;
    localparam logic [5:0] TBF_S_ABORT = 6'h02;
    localparam logic [5:0] TBF_S_WTX = 6'h03;
    localparam logic [5:0] TBF_S_VPP = 6'h24;
    localparam int TBF_APDU_DEPTH = 256;

    typedef enum logic [1:0] {TBF_BLK_I, TBF_BLK_R, TBF_BLK_S} tbf_blk_t;

    // Block type from the control byte alone
    function automatic tbf_blk_t tbf_type(input logic [7:0] pcb);
        if (!pcb[7]) begin
            return TBF_BLK_I;
        end else if (!pcb[6]) begin
            return TBF_BLK_R;
        end
        return TBF_BLK_S;
    endfunction

    // Information field length that an S-block must carry
    function automatic logic [7:0] tbf_s_len(input logic [7:0] pcb);
        if (pcb[4:0] == TBF_S_IFS[4:0] || pcb[4:0] == TBF_S_WTX[4:0]) begin
            return 8'h01;
        end
        return 8'h00;
    endfunction
endpackage

// File: hw/tbf_term.sv
// Terminal end of the block frame handler
`timescale 1ns/1ps
module tbf_term
    import tbf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    tbf_link_if.term link,
    input wire logic send,
    input wire logic [7:0] pcb,
    input wire logic [7:0] len,
    input wire logic [7:0] pay_data,
    output logic pay_rd,
    output logic busy,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_done,
    output logic rx_ok,
    output logic [7:0] rx_pcb
);
    typedef enum logic [1:0] {TBF_T_NAD, TBF_T_PCB, TBF_T_INF, TBF_T_EDC} tbf_tst_t;
    tbf_tst_t st_r;
    logic [7:0] lrc_r, len_r, cnt_r, nad_r;
    wire logic [7:0] b = link.c2t_data;
    wire logic lenchk = (tbf_type(rx_pcb) == TBF_BLK_I) ? (len_r != 8'h00) :
                        (tbf_type(rx_pcb) == TBF_BLK_R) ? (len_r == 8'h00) :
                        (len_r == tbf_s_len(rx_pcb));

    tbf_tx tbf_tx_inst (
        .clk(clk),
        .srst(srst),
        .start(send),
        .pcb(pcb),
        .len((len > TBF_MAX_INF) ? TBF_MAX_INF : len),
        .pay_data(pay_data),
        .pay_rd(pay_rd),
        .busy(busy),
        .out_data(link.t2c_data),
        .out_valid(link.t2c_valid),
        .out_last(link.t2c_last)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= TBF_T_NAD;
            lrc_r <= 8'h00;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            nad_r <= 8'h00;
            rx_pcb <= 8'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_done <= 1'b0;
            rx_ok <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            rx_done <= 1'b0;
            if (link.c2t_valid) begin
                lrc_r <= (st_r == TBF_T_NAD && cnt_r == 8'h00) ? b : (lrc_r ^ b);
                case (st_r)
                    TBF_T_NAD: begin
                        nad_r <= b;
                        st_r <= TBF_T_PCB;
                    end
                    TBF_T_PCB: begin
                        if (cnt_r == 8'h00) begin
                            rx_pcb <= b;
                            cnt_r <= 8'h01;
                        end else begin
                            len_r <= b;
                            cnt_r <= 8'h00;
                            st_r <= (b == 8'h00) ? TBF_T_EDC : TBF_T_INF;
                        end
                    end
                    TBF_T_INF: begin
                        rx_data <= b;
                        rx_valid <= 1'b1;
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r + 8'h01 == len_r) begin
                            st_r <= TBF_T_EDC;
                        end
                    end
                    TBF_T_EDC: begin
                        rx_done <= 1'b1;
                        rx_ok <= (lrc_r == b) && (nad_r == TBF_NAD_DEFAULT) && lenchk;
                        cnt_r <= 8'h00;
                        st_r <= TBF_T_NAD;
                    end
                    default: st_r <= TBF_T_NAD;
                endcase
            end
        end
    end
endmodule

// File: hw/tbf_tx.sv
// Block transmitter shared by both ends: header, payload and check byte
`timescale 1ns/1ps
module tbf_tx
    import tbf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [7:0] pcb,
    input wire logic [7:0] len,
    input wire logic [7:0] pay_data,
    output logic pay_rd,
    output logic busy,
    output logic [7:0] out_data,
    output logic out_valid,
    output logic out_last
);
    typedef enum logic [2:0] {TBF_TX_IDLE, TBF_TX_NAD, TBF_TX_PCB, TBF_TX_LEN,
                              TBF_TX_INF, TBF_TX_EDC} tbf_txst_t;
    tbf_txst_t st_r;
    logic [7:0] pcb_r, len_r, cnt_r, lrc_r;
    wire logic [7:0] cur = (st_r == TBF_TX_NAD) ? TBF_NAD_DEFAULT :
                           (st_r == TBF_TX_PCB) ? pcb_r :
                           (st_r == TBF_TX_LEN) ? len_r : pay_data;
    assign pay_rd = (st_r == TBF_TX_INF);
    assign busy = (st_r != TBF_TX_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= TBF_TX_IDLE;
            pcb_r <= 8'h00;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            lrc_r <= 8'h00;
            out_data <= 8'h00;
            out_valid <= 1'b0;
            out_last <= 1'b0;
        end else begin
            out_valid <= busy;
            out_last <= (st_r == TBF_TX_EDC);
            out_data <= (st_r == TBF_TX_EDC) ? lrc_r : cur;
            if (st_r != TBF_TX_EDC) begin
                lrc_r <= (st_r == TBF_TX_NAD) ? cur : (lrc_r ^ cur);
            end
            case (st_r)
                TBF_TX_IDLE: begin
                    if (start) begin
                        pcb_r <= pcb;
                        len_r <= len;
                        st_r <= TBF_TX_NAD;
                    end
                end
                TBF_TX_NAD: st_r <= TBF_TX_PCB;
                TBF_TX_PCB: st_r <= TBF_TX_LEN;
                TBF_TX_LEN: begin
                    cnt_r <= 8'h00;
                    st_r <= (len_r == 8'h00) ? TBF_TX_EDC : TBF_TX_INF;
                end
                TBF_TX_INF: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r + 8'h01 == len_r) begin
                        st_r <= TBF_TX_EDC;
                    end
                end
                TBF_TX_EDC: st_r <= TBF_TX_IDLE;
                default: st_r <= TBF_TX_IDLE;
            endcase
        end
    end
endmodule

// File: tb/tbf_link_sva.sv
// Checker watching the byte link between card and terminal
`timescale 1ns/1ps
module tbf_link_sva
    import tbf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] t2c_data,
    input wire logic t2c_valid,
    input wire logic t2c_last,
    input wire logic [7:0] c2t_data,
    input wire logic c2t_valid,
    input wire logic c2t_last
);
    logic [8:0] c_pos_r;
    logic [8:0] c_pos_nxt;
    logic [8:0] t_pos_r;
    logic [8:0] t_pos_nxt;
    logic [7:0] c_xor_r;
    logic [7:0] c_xor_nxt;
    logic [7:0] c_pcb_r;
    logic [7:0] c_len_r;
    logic [7:0] t_pcb_r;
    wire c_len_at = c2t_valid && (c_pos_r == 9'h002);
    wire s_one = (c_pcb_r[4:0] == TBF_S_IFS[4:0]) || (c_pcb_r[4:0] == TBF_S_WTX[4:0]);

    // Byte position and running check byte of the frame in flight
    assign c_pos_nxt = c2t_last ? 9'h000 : c_pos_r + 9'h001;
    assign t_pos_nxt = t2c_last ? 9'h000 : t_pos_r + 9'h001;
    assign c_xor_nxt = c2t_last ? 8'h00 : c_xor_r ^ c2t_data;

    always_ff @(posedge clk) begin
        if (srst) begin
            c_pos_r <= 9'h000;
            t_pos_r <= 9'h000;
            c_xor_r <= 8'h00;
        end else begin
            c_pos_r <= c2t_valid ? c_pos_nxt : c_pos_r;
            t_pos_r <= t2c_valid ? t_pos_nxt : t_pos_r;
            c_xor_r <= c2t_valid ? c_xor_nxt : c_xor_r;
        end
    end

    always_ff @(posedge clk) begin
        c_pcb_r <= (c2t_valid && c_pos_r == 9'h001) ? c2t_data : c_pcb_r;
        c_len_r <= c_len_at ? c2t_data : c_len_r;
        t_pcb_r <= (t2c_valid && t_pos_r == 9'h001) ? t2c_data : t_pcb_r;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    AST_C_NAD: assert property (c2t_valid && c_pos_r == 9'h000 |-> c2t_data == TBF_NAD_DEFAULT)
        else $error("card node address not zero");
    AST_T_NAD: assert property (t2c_valid && t_pos_r == 9'h000 |-> t2c_data == TBF_NAD_DEFAULT)
        else $error("terminal node address not zero");
    AST_EDC: assert property (c2t_valid && c2t_last |-> c2t_data == c_xor_r)
        else $error("card check byte wrong");
    AST_LEN_MATCH: assert property (c2t_valid && c2t_last |-> c_pos_r == {1'b0, c_len_r} + 9'h003)
        else $error("card length byte does not match field");
    AST_LEN_MAX: assert property (c_len_at |-> c2t_data <= TBF_MAX_INF)
        else $error("card length above maximum");
    AST_R_EMPTY: assert property (c_len_at && c_pcb_r[7:6] == 2'b10 |-> c2t_data == 8'h00)
        else $error("receive-ready block with field");
    AST_I_INF: assert property (c_len_at && !c_pcb_r[7] |-> c2t_data != 8'h00)
        else $error("information block without field");
    AST_S_LEN: assert property (c_len_at && c_pcb_r[7:6] == 2'b11 |-> c2t_data == {7'h00, s_one})
        else $error("supervisory block length wrong");
    AST_REPLY: assert property (t2c_valid && t2c_last && t_pcb_r[7:5] == 3'b110
        |-> ##3 (c2t_valid && c_pos_r == 9'h000))
        else $error("card reply did not start on time");
endmodule

// File: tb/tbf_tb_top.sv
// Testbench joining card and terminal ends, plus a raw driver on a second card
`timescale 1ns/1ps
module tbf_tb_top
    import tbf_pkg::*;
();
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic send = 1'b0;
    logic [7:0] pcb = 8'h00;
    logic [7:0] len = 8'h00;
    logic [7:0] pay_buf [0:255];
    logic [7:0] rsp_buf [0:255];
    logic [7:0] rx_buf [0:255];
    logic [7:0] cmd_buf [0:1023];
    logic [7:0] c2_buf [0:15];
    int pay_idx = 0, rsp_i = 0, rsp_len = 0, rx_n = 0, got_len = 0, frames = 0;
    int cmd_n = 0, c2_n = 0, c2_len = 0, c2_frames = 0, bad_count = 0, comparisons = 0;
    logic [7:0] got_pcb = 8'h00;
    logic got_ok = 1'b0;
    logic [7:0] cmd_data, ifsd, edc_choice, rx_data, rx_pcb, pay_data, rsp_data;
    logic cmd_valid, cmd_end, rsp_ready, frame_err, pay_rd, busy, rx_valid, rx_done, rx_ok;
    logic rsp_valid, rsp_end, frame_err2;
    int end_n = 0, err_n = 0;

    tbf_link_if lnk ();
    tbf_link_if lnk2 ();

    assign pay_data = pay_buf[pay_idx[7:0]];
    assign rsp_data = rsp_buf[rsp_i[7:0]];
    assign rsp_valid = rsp_i < rsp_len;
    assign rsp_end = rsp_i == rsp_len - 1;

    tbf_card tbf_card_inst (.clk(clk), .srst(srst), .link(lnk), .cmd_data(cmd_data),
        .cmd_valid(cmd_valid), .cmd_end(cmd_end), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .rsp_end(rsp_end), .rsp_ready(rsp_ready), .ifsd(ifsd), .edc_choice(edc_choice),
        .frame_err(frame_err));
    tbf_term tbf_term_inst (.clk(clk), .srst(srst), .link(lnk), .send(send), .pcb(pcb),
        .len(len), .pay_data(pay_data), .pay_rd(pay_rd), .busy(busy), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_done(rx_done), .rx_ok(rx_ok), .rx_pcb(rx_pcb));
    tbf_card tbf_card_inst2 (.clk(clk), .srst(srst), .link(lnk2), .cmd_data(), .cmd_valid(),
        .cmd_end(), .rsp_data(8'h00), .rsp_valid(1'b0), .rsp_end(1'b0), .rsp_ready(),
        .ifsd(), .edc_choice(), .frame_err(frame_err2));
    tbf_link_sva tbf_link_sva_inst (.clk(clk), .srst(srst), .t2c_data(lnk.t2c_data),
        .t2c_valid(lnk.t2c_valid), .t2c_last(lnk.t2c_last), .c2t_data(lnk.c2t_data),
        .c2t_valid(lnk.c2t_valid), .c2t_last(lnk.c2t_last));

    always #12.5 clk = ~clk;

    // Payload feed, response feed and collectors of what comes back
    always @(posedge clk) begin
        pay_idx <= send ? 0 : (pay_rd ? pay_idx + 1 : pay_idx);
        rsp_i <= !rsp_ready ? 0 : (rsp_valid ? rsp_i + 1 : rsp_i);
        if (cmd_end) end_n <= end_n + 1;
        if (frame_err || frame_err2) err_n <= err_n + 1;
        if (cmd_valid) begin
            cmd_buf[cmd_n[9:0]] <= cmd_data;
            cmd_n <= cmd_n + 1;
        end
        if (rx_valid) begin
            rx_buf[rx_n[7:0]] <= rx_data;
            rx_n <= rx_n + 1;
        end
        if (rx_done) begin
            got_len <= rx_n;
            got_pcb <= rx_pcb;
            got_ok <= rx_ok;
            rx_n <= 0;
            frames <= frames + 1;
        end
        if (lnk2.c2t_valid) begin
            c2_buf[c2_n[3:0]] <= lnk2.c2t_data;
            c2_n <= lnk2.c2t_last ? 0 : c2_n + 1;
            c2_len <= c2_n + 1;
            c2_frames <= lnk2.c2t_last ? c2_frames + 1 : c2_frames;
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic term_send(input logic [7:0] p, input logic [7:0] l);
        int f0;
        f0 = frames;
        @(posedge clk) #1;
        send = 1'b1;
        pcb = p;
        len = l;
        @(posedge clk) #1;
        send = 1'b0;
        for (int i = 0; i < 800 && frames == f0; i++) @(posedge clk) #1;
        chk8({7'h00, frames != f0}, 8'h01, "card reply missing");
    endtask

    task automatic check_rx(input logic [7:0] p, input logic [7:0] l, input int off);
        chk8(got_pcb, p, "control byte");
        chk8(got_len[7:0], l, "field length");
        chk8({7'h00, got_ok}, 8'h01, "frame check at terminal");
        if (!p[7]) for (int i = 0; i < l; i++) chk8(rx_buf[i], rsp_buf[off + i], "data byte");
    endtask

    task automatic raw_frame(input logic [7:0] nad, input logic [7:0] p, input logic [7:0] l,
                             input logic bad);
        logic [7:0] b [0:7];
        logic [7:0] x;
        int n;
        b[0] = nad;
        b[1] = p;
        b[2] = l;
        n = l + 3;
        x = 8'h00;
        for (int i = 0; i < l; i++) b[3 + i] = 8'h30 + i[7:0];
        for (int i = 0; i < n; i++) x = x ^ b[i];
        b[n] = bad ? ~x : x;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk) #1;
            lnk2.t2c_valid = 1'b1;
            lnk2.t2c_data = b[i];
            lnk2.t2c_last = (i == n);
        end
        @(posedge clk) #1;
        lnk2.t2c_valid = 1'b0;
        lnk2.t2c_last = 1'b0;
        lnk2.t2c_data = ~b[n];
    endtask

    task automatic wait2(output logic got);
        int f0;
        f0 = c2_frames;
        for (int i = 0; i < 60 && c2_frames == f0; i++) @(posedge clk) #1;
        got = c2_frames != f0;
    endtask

    task automatic t_reset;
        chk8(ifsd, 8'h20, "field size after reset");
        chk8(edc_choice, 8'h00, "error detection choice");
    endtask

    task automatic t_chain;
        int n0, e0;
        n0 = cmd_n;
        e0 = end_n;
        rsp_len = 40;
        term_send(8'h00, 8'h03);
        chk8(8'(end_n - e0), 8'h01, "command end count");
        chk8(8'(cmd_n - n0), 8'h03, "command byte count");
        chk8(cmd_buf[n0 + 2], 8'ha2, "command byte");
        check_rx(8'h20, 8'd32, 0);
        term_send(8'h90, 8'h00);
        check_rx(8'h40, 8'd8, 32);
    endtask

    task automatic t_ifs;
        pay_buf[0] = 8'hfe;
        term_send(8'hc1, 8'h01);
        check_rx(8'he1, 8'h01, 0);
        chk8(rx_buf[0], 8'hfe, "size answer value");
        chk8(ifsd, 8'hfe, "field size taken");
        pay_buf[0] = 8'hff;
        term_send(8'hc1, 8'h01);
        chk8(got_pcb & 8'hef, 8'h82, "oversize request refused");
        chk8(ifsd, 8'hfe, "field size kept");
        term_send(8'h40, 8'h02);
        check_rx(8'h00, 8'd40, 0);
    endtask

    task automatic t_resync_abort;
        term_send(8'hc0, 8'h00);
        check_rx(8'he0, 8'h00, 0);
        pay_buf[0] = 8'h20;
        term_send(8'hc1, 8'h01);
        chk8(ifsd, 8'h20, "field size back to default");
        term_send(8'h00, 8'h02);
        check_rx(8'h20, 8'd32, 0);
        term_send(8'hc2, 8'h00);
        check_rx(8'he2, 8'h00, 0);
    endtask

    task automatic t_bad_frames;
        logic got;
        raw_frame(8'h00, 8'h00, 8'h02, 1'b1);
        wait2(got);
        chk8(8'(c2_len), 8'h04, "reject length");
        chk8(c2_buf[1], 8'h81, "reject control byte");
        chk8(c2_buf[3], 8'h81, "reject check byte");
        chk8(8'(err_n), 8'h01, "frame error pulse");
        for (int k = 0; k < 3; k++) begin
            raw_frame((k == 0) ? 8'h10 : ((k == 1) ? 8'h01 : 8'h11), 8'h00, 8'h02, 1'b0);
            wait2(got);
            if (got) chk8(c2_buf[1], 8'h80, "bad address answer");
        end
        raw_frame(8'h00, 8'h20, 8'h02, 1'b0);
        wait2(got);
        chk8(c2_buf[1], 8'h90, "chain acknowledge");
        raw_frame(8'h00, 8'h40, 8'h01, 1'b1);
        wait2(got);
        chk8(c2_buf[1], 8'h91, "reject next expected");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up;
    end

    initial begin
        lnk2.t2c_valid = 1'b0;
        lnk2.t2c_last = 1'b0;
        lnk2.t2c_data = 8'h00;
        for (int i = 0; i < 256; i++) begin
            pay_buf[i] = 8'ha0 + i[7:0];
            rsp_buf[i] = i[7:0] ^ 8'h5a;
        end
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset;
        t_chain;
        t_ifs;
        t_resync_abort;
        t_bad_frames;
        wrap_up;
    end
endmodule
